// ---- ioc_consts.svh ----
// Purpose: constants for the channel halt, test and load sequencer
// Assumes: included by bare name
// Notes:   offsets are word byte addresses
`ifndef IOC_CONSTS_SVH
`define IOC_CONSTS_SVH
`define IOC_CC_AVAIL      2'h0
`define IOC_CC_STORED     2'h1
`define IOC_CC_BUSY       2'h2
`define IOC_CC_NOTOP      2'h3
`define IOC_CHAN_LSB      8
`define IOC_CHAN_MSB      10
`define IOC_ADDR_MSB      10
`define IOC_STEP_SIX      3'h6
`define IOC_CSW2_ADDR     8'h44
`define IOC_LOC_ZERO      8'h00
`define IOC_NEXT_CMD_ADDR 8'h08
`define IOC_LOAD_COUNT    8'h18
`define IOC_LOAD_CMD      8'h02
`define IOC_CMD_HALT_BIT  7
`define IOC_S2_PHASE      2'h2
`define IOC_MY_CHANNEL    3'h0
`endif

// ---- ioc_pkg.sv ----
// Purpose: types for the channel sequencer
// Assumes: nothing
// Notes:   none
package ioc_pkg;
  typedef enum logic [1:0] {
    IOC_OP_NONE = 2'h0,
    IOC_OP_TCH  = 2'h1,
    IOC_OP_HIO  = 2'h2,
    IOC_OP_LOAD = 2'h3
  } ioc_op_t;
  typedef enum logic [3:0] {
    IOC_IDLE   = 4'h0,
    IOC_STEP   = 4'h1,
    IOC_BHALT  = 4'h3,
    IOC_WAITDF = 4'h2,
    IOC_FETCH1 = 4'h6,
    IOC_FETCH2 = 4'h7,
    IOC_SEL    = 4'h5,
    IOC_STOP   = 4'h4,
    IOC_CSW    = 4'hC,
    IOC_STORE1 = 4'hD,
    IOC_STORE2 = 4'hF,
    IOC_LDRUN  = 4'hE,
    IOC_LDEND  = 4'hA,
    IOC_DONE   = 4'hB
  } ioc_state_t;
endpackage : ioc_pkg

// ---- ioc_tag_if.sv ----
// Purpose: tag interface between channel and control unit
// Assumes: one clock, levels sampled on clock_i
// Notes:   no clocking block
`timescale 1ns/1ps
`default_nettype none
interface ioc_tag_if;
  logic [7:0] bus_out;
  logic [7:0] bus_in;
  logic       address_out;
  logic       select_out;
  logic       select_in;
  logic       address_in;
  logic       status_in;
  logic       operational_in;
  logic       channel_end;
  modport channel (output bus_out, address_out, select_out,
                   input bus_in, select_in, address_in, status_in, operational_in, channel_end);
  modport unit (input bus_out, address_out, select_out,
                output bus_in, select_in, address_in, status_in, operational_in, channel_end);
endinterface : ioc_tag_if
`default_nettype wire

// ---- ioc_step_ctr.sv ----
// Purpose: compute step and interface pulse counter
// Assumes: run held while a sequence is active
// Notes:   step saturates at seven
`timescale 1ns/1ps
`default_nettype none
module ioc_step_ctr (
  input  wire logic       clock_i, // clock
  input  wire logic       rstn_i,  // async reset, low
  input  wire logic       run_i,   // count enable level
  output logic [2:0]      step_o,  // compute step
  output logic [1:0]      phase_o  // interface pulse phase
);
  logic [2:0] next_step;
  logic [1:0] next_phase;
  always_comb begin
    next_step  = run_i ? ((step_o == 3'h7) ? step_o : step_o + 3'h1) : 3'h0;
    next_phase = run_i ? phase_o + 2'h1 : 2'h0;
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      step_o  <= 3'h0;
      phase_o <= 2'h0;
    end else begin
      step_o  <= next_step;
      phase_o <= next_phase;
    end
  end
endmodule : ioc_step_ctr
`default_nettype wire

// ---- ioc_channel.sv ----
// Purpose: channel end: test channel, halt I/O and initial load sequencing
// Assumes: storage and processor side are plain ports
// Notes:   unit control words held in a small local array
`timescale 1ns/1ps
`default_nettype none
`include "ioc_consts.svh"
module ioc_channel (
  input  wire logic         clock_i,         // clock
  input  wire logic         rstn_i,          // async reset, low
  input  wire ioc_pkg::ioc_op_t op_i,        // operation request pulse
  input  wire logic         supervisor_i,    // processor in supervisor state
  input  wire logic [31:0]  b_operand_i,     // operand register, bit 0 msb
  input  wire logic [10:0]  load_unit_address_switches_i, // load address
  input  wire logic         burst_i,         // burst mode latch
  input  wire logic         io_irq_i,        // interrupt pending latch
  input  wire logic         data_flow_busy_i, // data flow occupied
  input  wire logic         chain_more_i,    // loaded command chains on
  output logic              end_execute_o,   // end-of-execute pulse
  output logic [1:0]        cond_code_o,     // condition code
  output logic              device_halted_o, // device halted latch
  output logic              zero_control_o,  // zero control latch
  output logic              load_psw_o,      // start status-word load pulse
  output logic              store_req_o,     // storage write pulse
  output logic [7:0]        storage_address_reg_o, // storage address
  output logic [31:0]       storage_data_reg_o,    // storage data
  output logic [7:0]        channel_data_reg_o,    // captured status byte
  ioc_tag_if.channel        tag              // tag interface
);
  ioc_pkg::ioc_state_t st, next_st;
  ioc_pkg::ioc_op_t    op, next_op;
  logic [10:0] addr, next_addr;
  logic [7:0]  cmd, next_cmd, channel_data_reg, next_cdr, storage_address_reg, next_sar, cnt, next_cnt;
  logic [31:0] storage_data_reg, next_sdr;
  logic        chain, next_chain, endf, next_endf, halted, next_halted;
  logic        zc, next_zc, ee, next_ee, st_req, next_st_req, lpsw, next_lpsw;
  logic        ao, next_ao, so, next_so, opin_q, next_opin_q;
  logic [1:0]  cc, next_cc;
  logic [7:0]  bo, next_bo;
  logic [31:0] unit_control_word [0:1];
  logic [31:0] next_ucw0, next_ucw1;
  logic [2:0]  step;
  logic [1:0]  phase;
  logic        run;
  logic        chan_ok;
  assign run = (st != ioc_pkg::IOC_IDLE);
  // operand bit n is vector bit 31-n
  assign chan_ok = (addr[`IOC_CHAN_MSB:`IOC_CHAN_LSB] == `IOC_MY_CHANNEL);
  ioc_step_ctr u_step (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .run_i   (run),
    .step_o  (step),
    .phase_o (phase)
  );
  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st; next_op = op; next_addr = addr; next_cmd = cmd;
    next_cdr = channel_data_reg; next_sar = storage_address_reg; next_sdr = storage_data_reg; next_cnt = cnt;
    next_chain = chain; next_endf = endf; next_halted = halted;
    next_zc = zc; next_ee = 1'b0; next_st_req = 1'b0; next_lpsw = 1'b0;
    next_ao = ao; next_so = so; next_cc = cc; next_bo = bo;
    next_opin_q = tag.operational_in;
    next_ucw0 = unit_control_word[0]; next_ucw1 = unit_control_word[1];
    case (st)
      ioc_pkg::IOC_IDLE: begin
        if (tag.channel_end) begin
          next_ucw1[31] = 1'b1;
        end
        if (op_i == ioc_pkg::IOC_OP_LOAD) begin
          next_op = op_i;
          next_addr = load_unit_address_switches_i;
          next_cmd = `IOC_LOAD_CMD;
          next_cnt = `IOC_LOAD_COUNT;
          next_chain = 1'b1;
          next_st = ioc_pkg::IOC_LDRUN;
        end else if (op_i != ioc_pkg::IOC_OP_NONE && supervisor_i) begin
          next_op = op_i;
          next_addr = (op_i == ioc_pkg::IOC_OP_TCH) ?
                      {b_operand_i[10:8], 8'h00} : b_operand_i[10:0];
          next_halted = 1'b0;
          next_zc = 1'b0;
          next_st = ioc_pkg::IOC_STEP;
        end
      end
      ioc_pkg::IOC_STEP: begin
        if (step == `IOC_STEP_SIX) begin
          if (!chan_ok) begin
            next_cc = `IOC_CC_NOTOP;
            next_st = ioc_pkg::IOC_DONE;
          end else if (op == ioc_pkg::IOC_OP_TCH) begin
            next_cc = burst_i ? `IOC_CC_BUSY :
                      (io_irq_i ? `IOC_CC_STORED : `IOC_CC_AVAIL);
            next_st = ioc_pkg::IOC_DONE;
          end else if (burst_i) begin
            next_chain = 1'b0;
            next_cmd[`IOC_CMD_HALT_BIT] = 1'b1;
            next_ao = 1'b1;
            next_st = ioc_pkg::IOC_BHALT;
          end else begin
            next_st = ioc_pkg::IOC_WAITDF;
          end
        end
      end
      ioc_pkg::IOC_BHALT: begin
        if (opin_q && !tag.operational_in) begin
          next_ao = 1'b0;
          next_halted = 1'b1;
          next_cc = `IOC_CC_BUSY;
          next_ee = 1'b1;
          next_st = ioc_pkg::IOC_STORE1;
        end
      end
      ioc_pkg::IOC_WAITDF: begin
        // step has saturated here, so halt the burst directly
        if (burst_i) begin
          next_chain = 1'b0;
          next_cmd[`IOC_CMD_HALT_BIT] = 1'b1;
          next_ao = 1'b1;
          next_st = ioc_pkg::IOC_BHALT;
        end else if (!data_flow_busy_i && phase == `IOC_S2_PHASE) begin
          next_cmd = unit_control_word[0][31:24];
          next_st = ioc_pkg::IOC_FETCH1;
        end
      end
      ioc_pkg::IOC_FETCH1: begin
        next_endf = unit_control_word[1][31];
        next_st = ioc_pkg::IOC_FETCH2;
      end
      ioc_pkg::IOC_FETCH2: begin
        if (endf) begin
          next_cc = `IOC_CC_AVAIL;
          next_ee = 1'b1;
          next_st = ioc_pkg::IOC_STORE1;
        end else begin
          next_cmd[`IOC_CMD_HALT_BIT] = 1'b1;
          next_chain = 1'b0;
          next_bo = addr[7:0];
          next_ao = 1'b1;
          next_so = 1'b1;
          next_st = ioc_pkg::IOC_SEL;
        end
      end
      ioc_pkg::IOC_SEL: begin
        if (tag.select_in) begin
          next_ao = 1'b0; next_so = 1'b0;
          next_cc = `IOC_CC_NOTOP;
          next_st = ioc_pkg::IOC_DONE;
        end else if (tag.address_in || tag.status_in) begin
          next_so = 1'b0;
          if (tag.status_in) begin
            next_cdr = tag.bus_in;
          end
          next_zc = 1'b1;
          next_st = ioc_pkg::IOC_CSW;
        end
      end
      ioc_pkg::IOC_CSW: begin
        next_ao = 1'b0;
        next_sar = `IOC_CSW2_ADDR;
        next_sdr = {channel_data_reg, 24'h000000};
        next_st_req = 1'b1;
        next_cc = `IOC_CC_STORED;
        next_ee = 1'b1;
        next_st = ioc_pkg::IOC_STORE1;
      end
      ioc_pkg::IOC_STORE1: begin
        next_ucw0 = {cmd, 13'h0000, addr};
        next_st = ioc_pkg::IOC_STORE2;
      end
      ioc_pkg::IOC_STORE2: begin
        next_ucw1 = {endf, chain, 6'h00, channel_data_reg, 16'h0000};
        next_st = ioc_pkg::IOC_IDLE;
      end
      ioc_pkg::IOC_LDRUN: begin
        if (tag.channel_end) begin
          if (chain && chain_more_i) begin
            next_sar = `IOC_NEXT_CMD_ADDR;
          end else begin
            next_st = ioc_pkg::IOC_LDEND;
          end
        end else if (cnt == 8'h00 && chain) begin
          next_sar = `IOC_NEXT_CMD_ADDR;
          next_chain = chain_more_i;
        end else if (cnt != 8'h00) begin
          next_cnt = cnt - 8'h01;
        end
      end
      ioc_pkg::IOC_LDEND: begin
        next_sar = `IOC_LOC_ZERO;
        next_sdr = {21'h000000, addr};
        next_st_req = 1'b1;
        next_lpsw = 1'b1;
        next_st = ioc_pkg::IOC_IDLE;
      end
      ioc_pkg::IOC_DONE: begin
        next_ee = 1'b1;
        next_st = ioc_pkg::IOC_IDLE;
      end
      default: next_st = ioc_pkg::IOC_IDLE;
    endcase
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= ioc_pkg::IOC_IDLE; op <= ioc_pkg::IOC_OP_NONE;
      addr <= 11'h000; cmd <= 8'h00; channel_data_reg <= 8'h00; storage_address_reg <= 8'h00; cnt <= 8'h00;
      storage_data_reg <= 32'h00000000; chain <= 1'b0; endf <= 1'b0; halted <= 1'b0;
      zc <= 1'b0; ee <= 1'b0; st_req <= 1'b0; lpsw <= 1'b0; ao <= 1'b0;
      so <= 1'b0; opin_q <= 1'b0; cc <= 2'h0; bo <= 8'h00;
      unit_control_word[0] <= 32'h00000000; unit_control_word[1] <= 32'h00000000;
    end else begin
      st <= next_st; op <= next_op; addr <= next_addr; cmd <= next_cmd;
      channel_data_reg <= next_cdr; storage_address_reg <= next_sar; cnt <= next_cnt; storage_data_reg <= next_sdr;
      chain <= next_chain; endf <= next_endf; halted <= next_halted;
      zc <= next_zc; ee <= next_ee; st_req <= next_st_req; lpsw <= next_lpsw;
      ao <= next_ao; so <= next_so; opin_q <= next_opin_q; cc <= next_cc;
      bo <= next_bo; unit_control_word[0] <= next_ucw0; unit_control_word[1] <= next_ucw1;
    end
  end
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign end_execute_o = ee;
  assign cond_code_o = cc;
  assign device_halted_o = halted;
  assign zero_control_o = zc;
  assign load_psw_o = lpsw;
  assign store_req_o = st_req;
  assign storage_address_reg_o = storage_address_reg;
  assign storage_data_reg_o = storage_data_reg;
  assign channel_data_reg_o = channel_data_reg;
  assign tag.bus_out = bo;
  assign tag.address_out = ao;
  assign tag.select_out = so;
endmodule : ioc_channel
`default_nettype wire

// ---- ioc_unit.sv ----
// Purpose: control unit end of the tag interface
// Assumes: one clock shared with channel
// Notes:   models attach, busy and burst as user levels
`timescale 1ns/1ps
`default_nettype none
`include "ioc_consts.svh"
module ioc_unit (
  input  wire logic       clock_i,     // clock
  input  wire logic       rstn_i,      // async reset, low
  input  wire logic [7:0] my_addr_i,   // device address
  input  wire logic       attached_i,  // device present
  input  wire logic       busy_i,      // unit busy
  input  wire logic [7:0] status_i,    // status byte when busy
  input  wire logic       burst_i,     // burst running
  input  wire logic       chan_end_i,  // channel end request
  output logic            stopped_o,   // stop order seen
  ioc_tag_if.unit         tag          // tag interface
);
  logic       si, next_si, ai, next_ai, sti, next_sti, op, next_op;
  logic       stp, next_stp, ce, next_ce;
  logic [7:0] bi, next_bi;
  logic       sel;
  assign sel = tag.select_out && tag.address_out;
  always_comb begin
    next_si  = sel && (tag.bus_out != my_addr_i || !attached_i);
    next_ai  = sel && !next_si && !busy_i;
    next_sti = sel && !next_si && busy_i;
    next_bi  = next_sti ? status_i : 8'h00;
    next_stp = stp;
    if (tag.address_out && !tag.select_out) begin
      next_stp = 1'b1;
    end else if (!tag.address_out) begin
      next_stp = 1'b0;
    end
    next_op = burst_i && !next_stp;
    next_ce = chan_end_i;
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      si <= 1'b0; ai <= 1'b0; sti <= 1'b0; op <= 1'b0; stp <= 1'b0;
      ce <= 1'b0; bi <= 8'h00;
    end else begin
      si <= next_si; ai <= next_ai; sti <= next_sti; op <= next_op;
      stp <= next_stp; ce <= next_ce; bi <= next_bi;
    end
  end
  assign tag.select_in = si;
  assign tag.address_in = ai;
  assign tag.status_in = sti;
  assign tag.bus_in = bi;
  assign tag.operational_in = op;
  assign tag.channel_end = ce;
  assign stopped_o = stp;
endmodule : ioc_unit
`default_nettype wire

// ---- ioc_sva.sv ----
// Purpose: tag interface checks between channel and control unit
// Assumes: one clock, levels sampled on the rising edge
// Notes:   takes the interface signals as plain inputs
`timescale 1ns/1ps
`default_nettype none
module ioc_chk (
  input  wire logic       clock_i,          // clock
  input  wire logic       rstn_i,           // async reset, low
  input  wire logic [7:0] bus_out_i,        // device address out
  input  wire logic       address_out_i,    // channel tag
  input  wire logic       select_out_i,     // channel tag
  input  wire logic       select_in_i,      // unit tag
  input  wire logic       address_in_i,     // unit tag
  input  wire logic       status_in_i,      // unit tag
  input  wire logic       operational_in_i  // unit tag
);
  // ----------
  // assertions
  // ----------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  sel_with_addr_a: assert property (select_out_i |-> address_out_i)
    else $error("select out without address out");
  addr_stable_a: assert property (
    (select_out_i && $past(select_out_i)) |-> $stable(bus_out_i))
    else $error("bus out moved during selection");
  unit_answers_a: assert property (
    $rose(select_out_i) |=> (select_in_i || address_in_i || status_in_i))
    else $error("no answer to selection");
  sel_in_alone_a: assert property (select_in_i |-> (!address_in_i && !status_in_i))
    else $error("select in mixed with other answer");
  sel_in_ends_a: assert property (
    (select_in_i && select_out_i) |-> ##[1:3] !select_out_i)
    else $error("selection kept after select in");
  addr_in_stop_a: assert property (
    (address_in_i && select_out_i) |-> ##[1:2] (address_out_i && !select_out_i))
    else $error("no stop order after address in");
  stop_ends_op_a: assert property (
    (address_out_i && !select_out_i && operational_in_i) |-> ##[1:2] !operational_in_i)
    else $error("unit kept running after stop");
  burst_break_a: assert property (
    ($rose(address_out_i) && operational_in_i) |-> !select_out_i)
    else $error("burst break raised select out");
endmodule : ioc_chk
`default_nettype wire

// ---- io_channel_halt_test_ipl_tb_top.sv ----
// Purpose: bench for channel and control unit joined by the tag interface
// Assumes: channel 0 is the valid channel
// Notes:   a monitor counts stores and end pulses
`timescale 1ns/1ps
`default_nettype none
`include "ioc_consts.svh"
module io_channel_halt_test_ipl_tb_top;
  // -------
  // signals
  // -------
  logic             clock_i = 1'b0;
  logic             rstn_i  = 1'b0;
  ioc_pkg::ioc_op_t op_i    = ioc_pkg::IOC_OP_NONE;
  logic             sup     = 1'b1;
  logic [31:0]      opnd    = 32'h0;
  logic [10:0]      load_unit_address_switches     = 11'h0A5;
  logic             burst   = 1'b0;
  logic             irq     = 1'b0;
  logic             dfb     = 1'b0;
  logic             more    = 1'b1;
  logic [7:0]       uaddr   = 8'h33;
  logic             att     = 1'b1;
  logic             busy    = 1'b0;
  logic [7:0]       ustat   = 8'hA5;
  logic             cend    = 1'b0;
  logic             ee, hlt, zc, program_status_word, st, stop;
  logic [1:0]       cc;
  logic [7:0]       storage_address_reg, channel_data_reg, selbus, st_sar;
  logic [31:0]      storage_data_reg, channel_status_word, st_sdr;
  logic [1:0]       tcc [4] = '{`IOC_CC_NOTOP, `IOC_CC_BUSY, `IOC_CC_STORED, `IOC_CC_AVAIL};
  int               errors = 0, comparisons = 0, cycles = 0, n_st = 0, n_ee = 0;
  ioc_tag_if tag ();

  ioc_channel ioc_channel_inst (.clock_i(clock_i), .rstn_i(rstn_i), .op_i(op_i),
    .supervisor_i(sup), .b_operand_i(opnd), .load_unit_address_switches_i(load_unit_address_switches),
    .burst_i(burst), .io_irq_i(irq), .data_flow_busy_i(dfb), .chain_more_i(more),
    .end_execute_o(ee), .cond_code_o(cc), .device_halted_o(hlt), .zero_control_o(zc),
    .load_psw_o(program_status_word), .store_req_o(st), .storage_address_reg_o(storage_address_reg),
    .storage_data_reg_o(storage_data_reg), .channel_data_reg_o(channel_data_reg), .tag(tag.channel));
  ioc_unit ioc_unit_inst (.clock_i(clock_i), .rstn_i(rstn_i), .my_addr_i(uaddr),
    .attached_i(att), .busy_i(busy), .status_i(ustat), .burst_i(burst),
    .chan_end_i(cend), .stopped_o(stop), .tag(tag.unit));
  ioc_chk ioc_chk_inst (.clock_i(clock_i), .rstn_i(rstn_i), .bus_out_i(tag.bus_out),
    .address_out_i(tag.address_out), .select_out_i(tag.select_out),
    .select_in_i(tag.select_in), .address_in_i(tag.address_in),
    .status_in_i(tag.status_in), .operational_in_i(tag.operational_in));

  always #4 clock_i = ~clock_i;

  // -------
  // monitor
  // -------
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (ee === 1'b1) n_ee <= n_ee + 1;
    if (tag.select_out === 1'b1) selbus <= tag.bus_out;
    if (st === 1'b1) begin
      n_st   <= n_st + 1;
      st_sar <= storage_address_reg;
      st_sdr <= storage_data_reg;
      if (storage_address_reg === `IOC_CSW2_ADDR) channel_status_word <= storage_data_reg;
    end
    if (cycles == 5000) begin
      errors = errors + 1;
      complete_run();
    end
  end

  // -----
  // tasks
  // -----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_ee(input int lim, output int lat);
    lat = 0;
    while (ee !== 1'b1 && lat < lim) begin
      @(negedge clock_i);
      lat++;
    end
  endtask : wait_ee

  task automatic run_op(input ioc_pkg::ioc_op_t op, input logic [31:0] b,
                        input int lim, output int lat);
    @(negedge clock_i);
    opnd = b;
    op_i = op;
    @(negedge clock_i);
    op_i = ioc_pkg::IOC_OP_NONE;
    wait_ee(lim, lat);
  endtask : run_op

  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // ------
  // tests
  // ------
  initial begin
    int lat;
    int s;
    repeat (16) @(posedge clock_i);
    @(negedge clock_i) rstn_i = 1'b1;
    // refused outside supervisor state
    sup = 1'b0;
    s = n_ee;
    run_op(ioc_pkg::IOC_OP_TCH, 32'h0000_00FF, 30, lat);
    check(32'(n_ee), 32'(s));
    sup = 1'b1;
    $display("supervisor refusal done");
    // test channel: invalid, burst, interrupt, free; low byte is junk
    for (int i = 0; i < 4; i++) begin
      burst = (i == 1);
      irq = (i == 2);
      run_op(ioc_pkg::IOC_OP_TCH, (i == 0) ? 32'h0000_01FF : 32'h0000_00FF, 200, lat);
      check(32'(cc), 32'(tcc[i]));
      check(32'(lat > 5 && lat < 11), 32'h1);
      repeat (8) @(negedge clock_i);
    end
    burst = 1'b0;
    irq = 1'b0;
    $display("test channel done");
    // halt with invalid channel
    run_op(ioc_pkg::IOC_OP_HIO, 32'h0000_0233, 200, lat);
    check(32'(cc), 32'(`IOC_CC_NOTOP));
    repeat (8) @(negedge clock_i);
    // halt during burst
    burst = 1'b1;
    repeat (4) @(negedge clock_i);
    s = n_st;
    run_op(ioc_pkg::IOC_OP_HIO, 32'h0000_0033, 200, lat);
    check(32'(cc), 32'(`IOC_CC_BUSY));
    check(32'(hlt), 32'h1);
    check(32'(stop), 32'h1);
    burst = 1'b0;
    repeat (12) @(negedge clock_i);
    check(ioc_channel_inst.unit_control_word[0], 32'h8000_0033);
    check(ioc_channel_inst.unit_control_word[1], 32'h0);
    $display("burst halt done");
    // halt free, busy and absent unit; data flow held busy first
    for (int i = 0; i < 3; i++) begin
      busy = (i == 1);
      att = (i != 2);
      dfb = 1'b1;
      s = n_st;
      run_op(ioc_pkg::IOC_OP_HIO, 32'h0000_0033, 20, lat);
      check(32'(lat), 32'd20);
      dfb = 1'b0;
      wait_ee(200, lat);
      if (i == 0) check(32'(stop), 32'h1);
      check(32'(selbus), 32'h33);
      check(32'(cc), (i == 2) ? 32'(`IOC_CC_NOTOP) : 32'(`IOC_CC_STORED));
      repeat (12) @(negedge clock_i);
      if (i < 2) begin
        check(32'(zc), 32'h1);
        check(channel_status_word[23:0], 24'h0);
        check(32'(n_st - s), 32'h1);
        check(ioc_channel_inst.unit_control_word[0], 32'h8000_0033);
        check(ioc_channel_inst.unit_control_word[1], (i == 1) ? 32'h00A5_0000 : 32'h0);
      end
      if (i == 1) check({channel_data_reg, channel_status_word[31:24]}, 16'hA5A5);
    end
    busy = 1'b0;
    att = 1'b1;
    $display("halt selection done");
    // pending channel end sets the end flag; halt answers 00 without selection
    cend = 1'b1;
    repeat (3) @(negedge clock_i);
    cend = 1'b0;
    s = n_st;
    run_op(ioc_pkg::IOC_OP_HIO, 32'h0000_0033, 200, lat);
    check(32'(cc), 32'(`IOC_CC_AVAIL));
    repeat (12) @(negedge clock_i);
    check(32'(n_st - s), 32'h0);
    check(32'(ioc_channel_inst.unit_control_word[1][31]), 32'h1);
    // burst begins while halt waits for data flow
    dfb = 1'b1;
    run_op(ioc_pkg::IOC_OP_HIO, 32'h0000_0033, 20, lat);
    burst = 1'b1;
    wait_ee(200, lat);
    check(32'(cc), 32'(`IOC_CC_BUSY));
    check(32'(hlt), 32'h1);
    burst = 1'b0;
    dfb = 1'b0;
    repeat (12) @(negedge clock_i);
    $display("halt end flag and late burst done");
    // initial load: chain on every cycle once the count is spent while more is high, then final channel end
    uaddr = 8'hA5;
    @(negedge clock_i);
    op_i = ioc_pkg::IOC_OP_LOAD;
    @(negedge clock_i);
    op_i = ioc_pkg::IOC_OP_NONE;
    repeat (40) @(negedge clock_i);
    check(32'(storage_address_reg), 32'(`IOC_NEXT_CMD_ADDR));
    more = 1'b0;
    cend = 1'b1;
    lat = 0;
    while (program_status_word !== 1'b1 && lat < 200) begin
      @(negedge clock_i);
      lat++;
    end
    check(32'(program_status_word), 32'h1);
    @(negedge clock_i);
    check(32'(st_sar), 32'(`IOC_LOC_ZERO));
    check(32'(st_sdr[10:0]), 32'(load_unit_address_switches));
    cend = 1'b0;
    $display("initial load done");
    complete_run();
  end
endmodule : io_channel_halt_test_ipl_tb_top
`default_nettype wire
